// ---- pmc_power_mgmt_memory_config.sv ----
`timescale 1ns/1ps
module pmc_power_mgmt_memory_config
  import pmc_pkg::*;
#(
  parameter int WARMUP_CYCLES = PMC_WARMUP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // switchback events
  input wire logic ext_int_ack,
  input wire logic ext_int_is_external,
  input wire logic serial_tx_start,
  input wire logic serial_rx_pin,
  input wire logic instr_start,
  // clock source control
  input wire logic clock_source_select,
  input wire logic xt_select_wr,
  input wire logic xtal_clk_pin,
  output logic crystal_enable,
  output logic crystal_warm_flag,
  output logic xt_select_allowed,
  output logic [1:0] clk_divide_sel,
  // address latch strobe
  input wire logic ale_request,
  input wire logic access_onchip,
  output logic ale_out,
  // data memory decode
  input wire logic data_req,
  input wire logic [15:0] data_addr,
  output logic sel_sram,
  output logic sel_external,
  output logic sel_scb,
  output logic sel_reserved,
  output logic [7:0] scb_rdata,
  // program lock
  input wire logic [2:0] program_lock_level,
  output logic verify_plain,
  output logic verify_encrypted,
  output logic code_read_block,
  output logic ext_data_block,
  output logic ext_exec_block,
  output logic erase_required,
  output logic lock_illegal
);

  logic switchback_enable;
  logic crystal_disable;
  logic latch_strobe_suppress;
  logic [1:0] data_mem_map_sel;
  logic [1:0] next_div;
  logic ctrl_write;
  logic [2:0] rx_sync;
  logic rx_level;
  logic rx_fall;
  logic rx_pending;
  logic int_switch;
  logic rx_switch;
  logic tx_switch;
  logic warm;

  assign ctrl_write = sfr_wr && (sfr_addr == PMC_CTRL_ADDR);

  // three stage receive pin sampler
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_sync <= 3'h7;
    else
      rx_sync <= {rx_sync[1:0], serial_rx_pin};
  end

  // receive line level, updated once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_level <= 1'b1;
    else if (rx_sync[2] == rx_sync[1])
      rx_level <= rx_sync[2];
  end

  assign rx_fall = rx_level && !rx_sync[2] && !rx_sync[1];

  // a start bit edge waits for the next instruction boundary
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_pending <= 1'b0;
    else if (rx_fall && switchback_enable)
      rx_pending <= 1'b1;
    else if (instr_start || !switchback_enable)
      rx_pending <= 1'b0;
  end

  // ack only arrives for an enabled, unmasked, vectored interrupt
  assign int_switch = switchback_enable && ext_int_ack && ext_int_is_external;
  assign rx_switch = rx_pending && instr_start;
  assign tx_switch = switchback_enable && serial_tx_start;

  // software write of the divider, with illegal steps dropped
  always_comb
  begin
    next_div = clk_divide_sel;
    if (ctrl_write)
    begin
      next_div = sfr_wdata[PMC_CD_HI:PMC_CD_LO];
      if (next_div == PMC_DIV_RSVD)
        next_div = clk_divide_sel;
      else if (next_div != PMC_DIV_4 && clk_divide_sel != PMC_DIV_4 && next_div != clk_divide_sel)
        next_div = clk_divide_sel;
    end
    if (int_switch || rx_switch || tx_switch)
      next_div = PMC_DIV_4;
  end

  // divider field; hardware switchback outranks a software write in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      clk_divide_sel <= PMC_CD_RESET;
    else
      clk_divide_sel <= next_div;
  end

  // plain control bits of the power management register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      switchback_enable <= PMC_SB_RESET;
      latch_strobe_suppress <= PMC_STROBE_SUPP_RESET;
      data_mem_map_sel <= PMC_DME_RESET;
    end
    else if (ctrl_write)
    begin
      switchback_enable <= sfr_wdata[PMC_SB_BIT];
      latch_strobe_suppress <= sfr_wdata[PMC_STROBE_SUPP_BIT];
      data_mem_map_sel <= sfr_wdata[PMC_DME_HI:PMC_DME_LO];
    end
  end

  // crystal disable: a one sticks only while on the ring oscillator
  always_ff @(posedge clk)
  begin
    if (rst)
      crystal_disable <= PMC_XTAL_DIS_RESET;
    else if (ctrl_write)
    begin
      if (!sfr_wdata[PMC_XTAL_DIS_BIT])
        crystal_disable <= 1'b0;
      else if (!clock_source_select)
        crystal_disable <= 1'b1;
    end
  end

  // amplifier runs while the disable bit is zero
  always_ff @(posedge clk)
  begin
    if (rst)
      crystal_enable <= 1'b1;
    else
      crystal_enable <= !crystal_disable;
  end

  // warmup counter restarts whenever the crystal is disabled
  pmc_warmup #(
    .WARMUP_CYCLES(WARMUP_CYCLES)
  ) u_warmup (
    .clk(clk),
    .rst(rst),
    .restart(crystal_disable),
    .xtal_clk_pin(xtal_clk_pin),
    .warm(warm)
  );

  // warm flag and gate for the clock source write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      crystal_warm_flag <= 1'b0;
      xt_select_allowed <= 1'b0;
    end
    else
    begin
      crystal_warm_flag <= warm;
      xt_select_allowed <= crystal_warm_flag || !xt_select_wr;
    end
  end

  // register read port; reserved bit four returns zero
  always_ff @(posedge clk)
  begin
    if (rst)
      sfr_rdata <= 8'h0;
    else if (sfr_rd && sfr_addr == PMC_CTRL_ADDR)
    begin
      sfr_rdata <= 8'h0;
      sfr_rdata[PMC_CD_HI:PMC_CD_LO] <= clk_divide_sel;
      sfr_rdata[PMC_SB_BIT] <= switchback_enable;
      sfr_rdata[PMC_RSVD_BIT] <= 1'b0;
      sfr_rdata[PMC_XTAL_DIS_BIT] <= crystal_disable;
      sfr_rdata[PMC_STROBE_SUPP_BIT] <= latch_strobe_suppress;
      sfr_rdata[PMC_DME_HI:PMC_DME_LO] <= data_mem_map_sel;
    end
    else
      sfr_rdata <= 8'h0;
  end

  // strobe: external accesses always strobe, on-chip ones honour the suppress bit
  always_ff @(posedge clk)
  begin
    if (rst)
      ale_out <= 1'b0;
    else
      ale_out <= ale_request && (!access_onchip || !latch_strobe_suppress);
  end

  // data memory decode, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_sram <= 1'b0;
      sel_external <= 1'b0;
      sel_scb <= 1'b0;
      sel_reserved <= 1'b0;
    end
    else
    begin
      sel_sram <= 1'b0;
      sel_external <= 1'b0;
      sel_scb <= 1'b0;
      sel_reserved <= 1'b0;
      if (data_req)
      begin
        case (data_mem_map_sel)
          PMC_MAP_EXT:
            sel_external <= 1'b1;
          PMC_MAP_SRAM:
          begin
            if (data_addr <= PMC_SRAM_LAST)
              sel_sram <= 1'b1;
            else
              sel_external <= 1'b1;
          end
          PMC_MAP_SCB:
          begin
            if (data_addr <= PMC_SRAM_LAST)
              sel_sram <= 1'b1;
            else if (data_addr == PMC_SCB_ADDR)
              sel_scb <= 1'b1;
            else
              sel_reserved <= 1'b1;
          end
          default:
            sel_reserved <= 1'b1;
        endcase
      end
    end
  end

  // control byte data; no write path exists, so software cannot alter it
  always_ff @(posedge clk)
  begin
    if (rst)
      scb_rdata <= 8'h0;
    else if (data_req && data_mem_map_sel == PMC_MAP_SCB && data_addr == PMC_SCB_ADDR)
      scb_rdata <= {PMC_SCB_RSVD_ONES, program_lock_level};
    else
      scb_rdata <= 8'h0;
  end

  // lock level permissions
  pmc_lock_decode u_lock (
    .clk(clk),
    .rst(rst),
    .program_lock_level(program_lock_level),
    .verify_plain(verify_plain),
    .verify_encrypted(verify_encrypted),
    .code_read_block(code_read_block),
    .ext_data_block(ext_data_block),
    .ext_exec_block(ext_exec_block),
    .erase_required(erase_required),
    .lock_illegal(lock_illegal)
  );

endmodule : pmc_power_mgmt_memory_config

// ---- pmc_pkg.sv ----
package pmc_pkg;

  // power management register position in the special function space
  localparam logic [7:0] PMC_CTRL_ADDR = 8'hc4;

  // field positions inside power_mgmt_ctrl
  localparam int PMC_CD_HI = 7;
  localparam int PMC_CD_LO = 6;
  localparam int PMC_SB_BIT = 5;
  localparam int PMC_RSVD_BIT = 4;
  localparam int PMC_XTAL_DIS_BIT = 3;
  localparam int PMC_STROBE_SUPP_BIT = 2;
  localparam int PMC_DME_HI = 1;
  localparam int PMC_DME_LO = 0;

  // reset values
  localparam logic [1:0] PMC_CD_RESET = 2'h1;
  localparam logic PMC_SB_RESET = 1'b0;
  localparam logic PMC_XTAL_DIS_RESET = 1'b0;
  localparam logic PMC_STROBE_SUPP_RESET = 1'b0;
  localparam logic [1:0] PMC_DME_RESET = 2'h0;

  // clock divide select encodings
  typedef enum logic [1:0] {
    PMC_DIV_RSVD = 2'b00,
    PMC_DIV_4 = 2'b01,
    PMC_DIV_64 = 2'b10,
    PMC_DIV_1024 = 2'b11
  } pmc_div_t;

  // data memory map select encodings
  typedef enum logic [1:0] {
    PMC_MAP_EXT = 2'b00,
    PMC_MAP_SRAM = 2'b01,
    PMC_MAP_RSVD = 2'b10,
    PMC_MAP_SCB = 2'b11
  } pmc_map_t;

  // data memory decode boundaries
  localparam logic [15:0] PMC_SRAM_LAST = 16'h03ff;
  localparam logic [15:0] PMC_SCB_ADDR = 16'hfffc;
  localparam logic [4:0] PMC_SCB_RSVD_ONES = 5'h1f;

  // program lock levels
  localparam logic [2:0] PMC_LOCK_NONE = 3'h0;
  localparam logic [2:0] PMC_LOCK_ENCRYPT = 3'h1;
  localparam logic [2:0] PMC_LOCK_NOVERIFY = 3'h3;
  localparam logic [2:0] PMC_LOCK_FULL = 3'h7;

  // crystal warmup length in crystal cycles
  localparam int PMC_WARMUP_CYCLES = 65536;

endpackage : pmc_pkg

// ---- pmc_warmup.sv ----
`timescale 1ns/1ps
module pmc_warmup
  import pmc_pkg::*;
#(
  parameter int WARMUP_CYCLES = PMC_WARMUP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  // crystal clock pin
  input wire logic xtal_clk_pin,
  // status
  output logic warm
);

  logic [2:0] xtal_sync;
  logic xtal_level;
  logic [16:0] edge_count;

  // three stage sampler; the crystal must run at a quarter of clk or slower to be counted
  always_ff @(posedge clk)
  begin
    if (rst)
      xtal_sync <= 3'h0;
    else
      xtal_sync <= {xtal_sync[1:0], xtal_clk_pin};
  end

  // debounced level changes only when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      xtal_level <= 1'b0;
    else if (xtal_sync[2] == xtal_sync[1])
      xtal_level <= xtal_sync[2];
  end

  // count rising crystal edges; restart holds the counter at zero
  always_ff @(posedge clk)
  begin
    if (rst || restart)
    begin
      edge_count <= 17'h0;
      warm <= 1'b0;
    end
    else if (!warm && xtal_sync[2] && xtal_sync[1] && !xtal_level)
    begin
      edge_count <= edge_count + 17'h1;
      if (edge_count == 17'(WARMUP_CYCLES - 1))
        warm <= 1'b1;
    end
  end

endmodule : pmc_warmup

// ---- pmc_lock_decode.sv ----
`timescale 1ns/1ps
module pmc_lock_decode
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // lock level from the nonvolatile byte
  input wire logic [2:0] program_lock_level,
  // permissions
  output logic verify_plain,
  output logic verify_encrypted,
  output logic code_read_block,
  output logic ext_data_block,
  output logic ext_exec_block,
  output logic erase_required,
  output logic lock_illegal
);

  // registered so the permission outputs never glitch; unknown levels lock hardest
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      verify_plain <= 1'b0;
      verify_encrypted <= 1'b0;
      code_read_block <= 1'b1;
      ext_data_block <= 1'b1;
      ext_exec_block <= 1'b1;
      erase_required <= 1'b1;
      lock_illegal <= 1'b0;
    end
    else
    begin
      verify_plain <= 1'b0;
      verify_encrypted <= 1'b0;
      code_read_block <= 1'b1;
      ext_data_block <= 1'b1;
      ext_exec_block <= 1'b1;
      erase_required <= 1'b1;
      lock_illegal <= 1'b0;
      case (program_lock_level)
        PMC_LOCK_NONE:
        begin
          verify_plain <= 1'b1;
          code_read_block <= 1'b0;
          ext_data_block <= 1'b0;
          ext_exec_block <= 1'b0;
          erase_required <= 1'b0;
        end
        PMC_LOCK_ENCRYPT:
        begin
          verify_encrypted <= 1'b1;
          ext_data_block <= 1'b0;
          ext_exec_block <= 1'b0;
        end
        PMC_LOCK_NOVERIFY:
        begin
          ext_exec_block <= 1'b0;
        end
        PMC_LOCK_FULL:
        begin
          ext_exec_block <= 1'b1;
        end
        default:
        begin
          lock_illegal <= 1'b1;
        end
      endcase
    end
  end

endmodule : pmc_lock_decode

// ---- pmc_properties.sv ----
`timescale 1ns/1ps
module pmc_properties
  import pmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs of the block
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic ext_int_ack,
  input wire logic ext_int_is_external,
  input wire logic serial_tx_start,
  input wire logic clock_source_select,
  input wire logic xt_select_wr,
  input wire logic ale_request,
  input wire logic access_onchip,
  input wire logic data_req,
  input wire logic [15:0] data_addr,
  input wire logic [2:0] program_lock_level,
  // outputs of the block
  input wire logic crystal_enable,
  input wire logic crystal_warm_flag,
  input wire logic xt_select_allowed,
  input wire logic [1:0] clk_divide_sel,
  input wire logic ale_out,
  input wire logic sel_sram,
  input wire logic sel_external,
  input wire logic sel_scb,
  input wire logic sel_reserved,
  input wire logic [7:0] scb_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] map;
  logic sb_en;
  logic supp;
  logic ctrl_wr;
  assign ctrl_wr = sfr_wr && sfr_addr == PMC_CTRL_ADDR;
  // shadow copy, so the checks need no internal probes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      map <= 2'h0;
      sb_en <= 1'b0;
      supp <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      map <= sfr_wdata[1:0];
      sb_en <= sfr_wdata[5];
      supp <= sfr_wdata[2];
    end
  end
  property p_div_legal; clk_divide_sel != 2'h0; endproperty
  a_div_legal: assert property (p_div_legal) else $error("divider field reserved");
  property p_sb_tx; sb_en && serial_tx_start && !ctrl_wr |=> clk_divide_sel == 2'h1; endproperty
  a_sb_tx: assert property (p_sb_tx) else $error("no switchback on transmit");
  property p_sb_int; sb_en && ext_int_ack && ext_int_is_external && !ctrl_wr |=> clk_divide_sel == 2'h1; endproperty
  a_sb_int: assert property (p_sb_int) else $error("no switchback on interrupt");
  // enable lags the disable bit by a cycle, so a refused write shows one cycle later
  property p_crystal_disable; ctrl_wr && sfr_wdata[3] && clock_source_select |=> ##1 $stable(crystal_enable); endproperty
  a_crystal_disable: assert property (p_crystal_disable) else $error("crystal stopped while running on it");
  property p_xt_block; xt_select_wr && !crystal_warm_flag |=> !xt_select_allowed; endproperty
  a_xt_block: assert property (p_xt_block) else $error("crystal select not blocked");
  property p_ale; ale_request && (!access_onchip || !supp) |=> ale_out; endproperty
  a_ale: assert property (p_ale) else $error("strobe missing");
  property p_sel_one; data_req |=> $onehot({sel_sram, sel_external, sel_scb, sel_reserved}); endproperty
  a_sel_one: assert property (p_sel_one) else $error("select not one-hot");
  property p_map_ext; map == 2'h0 && data_req |=> sel_external; endproperty
  a_map_ext: assert property (p_map_ext) else $error("map zero not external");
  property p_map_sram; map[0] && data_req && data_addr <= 16'h03ff |=> sel_sram; endproperty
  a_map_sram: assert property (p_map_sram) else $error("low area not internal");
  property p_scb; map == 2'h3 && data_req && data_addr == 16'hfffc |=> sel_scb && scb_rdata == {5'h1f, $past(program_lock_level)};
  endproperty
  a_scb: assert property (p_scb) else $error("control byte wrong");
  property p_scb_gate; map != 2'h3 && data_req |=> !sel_scb; endproperty
  a_scb_gate: assert property (p_scb_gate) else $error("control byte outside map three");
  c_sb: cover property (sb_en && serial_tx_start);
  c_scb: cover property (sel_scb);
  c_warm: cover property ($rose(crystal_warm_flag));
endmodule : pmc_properties
bind pmc_power_mgmt_memory_config pmc_properties u_pmc_properties (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
  .ext_int_ack, .ext_int_is_external, .serial_tx_start, .clock_source_select, .xt_select_wr, .ale_request,
  .access_onchip, .data_req, .data_addr, .program_lock_level, .crystal_enable, .crystal_warm_flag,
  .xt_select_allowed, .clk_divide_sel, .ale_out, .sel_sram, .sel_external, .sel_scb, .sel_reserved, .scb_rdata);

// ---- pmc_power_mgmt_memory_config_bench.sv ----
`timescale 1ns/1ps
module pmc_power_mgmt_memory_config_bench
  import pmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'hc4, sfr_wdata = 8'h00, rd, sfr_rdata, scb_rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, ext_int_ack = 1'b0, ext_int_is_external = 1'b0, serial_tx_start = 1'b0;
  logic serial_rx_pin = 1'b1, instr_start = 1'b0, clock_source_select = 1'b0, xt_select_wr = 1'b0;
  logic xtal_clk_pin = 1'b0, ale_request = 1'b0, access_onchip = 1'b0, data_req = 1'b0;
  logic [15:0] data_addr = 16'h0000;
  logic [2:0] program_lock_level = 3'h3;
  logic [1:0] clk_divide_sel;
  logic crystal_enable, crystal_warm_flag, xt_select_allowed, ale_out, sel_sram, sel_external, sel_scb;
  logic sel_reserved, verify_plain, verify_encrypted, code_read_block, ext_data_block, ext_exec_block;
  logic erase_required, lock_illegal;
  int errors = 0;
  int compares = 0;
  // map, address, selects {sram, ext, scb, reserved}, control byte
  logic [29:0] rows [10] = '{{2'h0, 16'h0000, 4'h4, 8'h00}, {2'h0, 16'hffff, 4'h4, 8'h00},
    {2'h1, 16'h03ff, 4'h8, 8'h00}, {2'h1, 16'h0400, 4'h4, 8'h00}, {2'h2, 16'h0010, 4'h1, 8'h00},
    {2'h3, 16'h0000, 4'h8, 8'h00}, {2'h3, 16'hfffc, 4'h2, 8'hfb}, {2'h3, 16'hfffb, 4'h1, 8'h00},
    {2'h3, 16'hfffd, 4'h1, 8'h00}, {2'h3, 16'h0400, 4'h1, 8'h00}};

  // short warmup keeps the run brief
  pmc_power_mgmt_memory_config #(.WARMUP_CYCLES(16)) u_pmc_power_mgmt_memory_config (.clk, .rst, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .ext_int_ack, .ext_int_is_external, .serial_tx_start,
    .serial_rx_pin, .instr_start, .clock_source_select, .xt_select_wr, .xtal_clk_pin, .crystal_enable,
    .crystal_warm_flag, .xt_select_allowed, .clk_divide_sel, .ale_request, .access_onchip, .ale_out,
    .data_req, .data_addr, .sel_sram, .sel_external, .sel_scb, .sel_reserved, .scb_rdata,
    .program_lock_level, .verify_plain, .verify_encrypted, .code_read_block, .ext_data_block,
    .ext_exec_block, .erase_required, .lock_illegal);

  // core clock, and a crystal at a quarter of its rate
  always #20 clk = ~clk;
  always #80 xtal_clk_pin = ~xtal_clk_pin;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one register write, result visible on return
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdr;
    @(posedge clk);
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    rd = sfr_rdata;
  endtask : rdr

  // watchdog, generous against roughly 260 cycles of tests
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h01);
    rdr();
    chk("ctrl", rd, 8'h40);
    for (int i = 0; i < 10; i++)
    begin
      wr({6'h10, rows[i][29:28]});
      @(posedge clk);
      data_req <= 1'b1;
      data_addr <= rows[i][27:12];
      @(posedge clk);
      data_req <= 1'b0;
      #1;
      chk("sel", {4'h0, sel_sram, sel_external, sel_scb, sel_reserved}, {4'h0, rows[i][11:8]});
      chk("scb", scb_rdata, rows[i][7:0]);
    end
    // divider moves, including refused ones
    wr(8'h80);
    chk("div", {6'h0, clk_divide_sel}, 8'h02);
    wr(8'hc0);
    chk("div", {6'h0, clk_divide_sel}, 8'h02);
    wr(8'h00);
    chk("div", {6'h0, clk_divide_sel}, 8'h02);
    wr(8'h40);
    wr(8'hc0);
    @(posedge clk);
    serial_tx_start <= 1'b1;
    @(posedge clk);
    serial_tx_start <= 1'b0;
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h03);
    wr(8'h60);
    wr(8'he0);
    @(posedge clk);
    serial_tx_start <= 1'b1;
    @(posedge clk);
    serial_tx_start <= 1'b0;
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h01);
    // internal interrupt first, then external
    for (int k = 0; k < 2; k++)
    begin
      wr(8'he0);
      @(posedge clk);
      ext_int_ack <= 1'b1;
      ext_int_is_external <= k[0];
      @(posedge clk);
      ext_int_ack <= 1'b0;
      #1;
      chk("div", {6'h0, clk_divide_sel}, k ? 8'h01 : 8'h03);
    end
    wr(8'he0);
    @(posedge clk);
    serial_rx_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h03);
    @(posedge clk);
    instr_start <= 1'b1;
    @(posedge clk);
    instr_start <= 1'b0;
    serial_rx_pin <= 1'b1;
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h01);
    // software keeps the reserved bit at zero on every write
    wr(8'h40);
    rdr();
    chk("ctrl", rd, 8'h40);
    // crystal stop and restart; the enable output follows one cycle after the bit
    @(posedge clk);
    clock_source_select <= 1'b1;
    wr(8'h48);
    @(posedge clk);
    #1;
    chk("xt_en", {7'h0, crystal_enable}, 8'h01);
    @(posedge clk);
    clock_source_select <= 1'b0;
    wr(8'h48);
    @(posedge clk);
    #1;
    chk("xt_en", {7'h0, crystal_enable}, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
      begin
        wr(8'h40);
        @(posedge clk);
        #1;
        chk("xt_en", {7'h0, crystal_enable}, 8'h01);
        repeat (100) @(posedge clk);
      end
      @(posedge clk);
      xt_select_wr <= 1'b1;
      @(posedge clk);
      xt_select_wr <= 1'b0;
      #1;
      chk("warm", {7'h0, crystal_warm_flag}, {7'h0, k[0]});
      chk("xt_ok", {7'h0, xt_select_allowed}, {7'h0, k[0]});
    end
    // strobe with and without suppression
    for (int k = 0; k < 4; k++)
    begin
      wr(k[1] ? 8'h44 : 8'h40);
      @(posedge clk);
      ale_request <= 1'b1;
      access_onchip <= k[0];
      @(posedge clk);
      ale_request <= 1'b0;
      #1;
      chk("ale", {7'h0, ale_out}, (k == 3) ? 8'h00 : 8'h01);
    end
    for (int v = 0; v < 8; v++)
    begin
      @(posedge clk);
      program_lock_level <= v[2:0];
      repeat (2) @(posedge clk);
      #1;
      chk("lock", {4'h0, verify_plain, verify_encrypted, erase_required, lock_illegal},
        {4'h0, v == 0, v == 1, v != 0, !(v == 0 || v == 1 || v == 3 || v == 7)});
      chk("exec", {7'h0, ext_exec_block}, {7'h0, !(v == 0 || v == 1 || v == 3)});
      chk("code_rd", {7'h0, code_read_block}, {7'h0, v != 0});
      chk("ext_data", {7'h0, ext_data_block}, {7'h0, !(v == 0 || v == 1)});
    end
    // mid-run reset brings the register and the map back to their reset state
    wr(8'h87);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("div", {6'h0, clk_divide_sel}, 8'h01);
    rdr();
    chk("ctrl", rd, 8'h40);
    @(posedge clk);
    data_req <= 1'b1;
    data_addr <= 16'h0000;
    @(posedge clk);
    data_req <= 1'b0;
    #1;
    chk("sel", {4'h0, sel_sram, sel_external, sel_scb, sel_reserved}, 8'h04);
    complete_run();
  end
endmodule : pmc_power_mgmt_memory_config_bench
